/* design/tfv_pkg.sv */
// Constants, types and helpers shared by the two-of-four trip voter
// Behaviour
// RULE_01: Each voter channel trips only when two or more of the four measurement channels present a trip.
// RULE_02: Each voter channel drives redundant trip outputs, each one feeding its own interface relay.
// RULE_03: At most one measurement channel may be bypassed at a time and voter channels cannot be bypassed.
// RULE_04: A single unbypassed channel trip gives a half-trip in all four voters and no trip to either trip system.
// RULE_05: Trips from two unbypassed channels give a full trip in all four voters, two trip inputs per trip system.
// RULE_06: The oscillation trip is enabled only while power is above 30 percent and flow below 60 percent.
// RULE_07: The average power trip has no automatic bypass and always reaches the vote. The code masks it out of the vote while its channel is bypassed.
// RULE_08: The average power threshold drops to the setdown value whenever the mode selector is not in run.
// RULE_09: The oscillation upscale trip is merged with the channel inoperative flag into one oscillation vote input.
// RULE_10: A bypassed channel's trip and inoperative flags add nothing to any vote while the bypass stands.
// RULE_11: The oscillation enable is re-evaluated every cycle so leaving the zone removes its vote at once.
package tfv_pkg;

  localparam int NUM_CHAN = 4;
  localparam int NUM_VOTER = 4;
  localparam int OUT_PER_VOTER = 2;
  localparam logic [2:0] VOTE_FULL_MIN = 3'h2;
  localparam logic [2:0] VOTE_HALF = 3'h1;

  // Zone limits and thresholds in percent of rated
  localparam logic [7:0] OSC_POWER_MIN = 8'h1e;
  localparam logic [7:0] OSC_FLOW_MAX = 8'h3c;
  localparam logic [7:0] STP_RUN_RST = 8'h72;
  localparam logic [7:0] STP_SETDOWN_RST = 8'h0f;

  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STP_RUN = 8'h04;
  localparam logic [7:0] REG_STP_SETDOWN = 8'h08;
  localparam logic [7:0] REG_STATE = 8'h0c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;

  // Field positions
  localparam int CTRL_BYP_EN_BIT = 0;
  localparam int CTRL_BYP_IDX_LSB = 1;
  localparam int IRQ_HALF_BIT = 0;
  localparam int IRQ_FULL_BIT = 1;
  localparam int IRQ_ZONE_BIT = 2;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // One measurement channel as seen at the pins
  typedef struct packed {
    logic oscUpscale;
    logic avgInop;
    logic [7:0] powerPct;
    logic [7:0] flowPct;
  } tfv_chan_in_t;

  // Number of set bits in a four-channel vote
  function automatic logic [2:0] tripCount(input logic [3:0] v);
    tripCount = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
  endfunction : tripCount

  // Power and flow inside the oscillation enable zone
  function automatic logic zoneOk(input tfv_chan_in_t c);
    zoneOk = (c.powerPct > OSC_POWER_MIN) && (c.flowPct < OSC_FLOW_MAX);
  endfunction : zoneOk

endpackage : tfv_pkg

/* design/tfv_vote_cell.sv */
// One voter channel: two-of-four vote with redundant registered outputs
module tfv_vote_cell #(
  parameter int NUM_OUT = tfv_pkg::OUT_PER_VOTER
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] voteIn,
  output logic [NUM_OUT-1:0] tripOut,
  output logic halfTrip
);

  typedef struct packed {
    logic [NUM_OUT-1:0] trip;
    logic half;
  } tfv_cell_state_t;

  tfv_cell_state_t state_q;
  tfv_cell_state_t state_d;
  logic [2:0] count;

  // Count votes; the cell has no bypass input of its own
  always_comb begin
    count = tfv_pkg::tripCount(voteIn);
    state_d.trip = {NUM_OUT{count >= tfv_pkg::VOTE_FULL_MIN}}; // RULE_01 RULE_05
    state_d.half = (count == tfv_pkg::VOTE_HALF); // RULE_04
  end

  // Every output has its own flip-flop so each relay driver stands alone
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d; // RULE_02
    end
  end

  assign tripOut = state_q.trip;
  assign halfTrip = state_q.half;

  a_cell_full_vote: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
    (tfv_pkg::tripCount(voteIn) >= 3'h2) |=> (&tripOut && !halfTrip))
    else $error("voter missed a two-of-four trip");

  a_cell_no_trip: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
    (tfv_pkg::tripCount(voteIn) < 3'h2) |=> (tripOut == '0))
    else $error("voter tripped on fewer than two votes");

endmodule : tfv_vote_cell

/* design/tfv_voter.sv */
// Trip voter top: input sync, trip functions, bypass, four voters, registers
//
// The register addresses and the address-and-strobe port are this design's own decisions.
module tfv_voter #(
  parameter int NUM_OUT = tfv_pkg::OUT_PER_VOTER
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire tfv_pkg::tfv_chan_in_t [3:0] chanIn,
  input wire logic modeRunPin,
  input wire logic [7:0] busAddr,
  input wire logic [31:0] busWrData,
  input wire logic busWrStb,
  input wire logic busRdStb,
  output logic [31:0] busRdData,
  output logic [3:0][NUM_OUT-1:0] ptsTrip,
  output logic [3:0] halfTripInd,
  output logic irq
);

  typedef struct packed {
    tfv_pkg::tfv_chan_in_t [3:0] chanMeta;
    tfv_pkg::tfv_chan_in_t [3:0] chan;
    logic modeMeta;
    logic modeRun;
    logic [3:0] avgTrip;
    logic [3:0] oscEn;
    logic [3:0] voteIn;
    logic bypassEn;
    logic [1:0] bypassIdx;
    logic [7:0] stpRun;
    logic [7:0] stpSetdown;
    logic [2:0] irqStat;
    logic [2:0] irqMask;
    logic halfPrev;
    logic fullPrev;
    logic zonePrev;
    logic [31:0] rdData;
  } tfv_state_t;

  tfv_state_t state_q;
  tfv_state_t state_d;
  logic [3:0] oscVote;
  logic [3:0] bypMask;
  logic [7:0] stpSel;
  logic [2:0] voteCount;
  logic [2:0] events;
  logic [2:0] irqClr;
  logic [31:0] rdMux;
  logic [3:0][NUM_OUT-1:0] cellTrip;
  logic [3:0] cellHalf;

  // Threshold follows the synchronised mode selector
  assign stpSel = state_q.modeRun ? state_q.stpRun : state_q.stpSetdown; // RULE_08

  // One-hot mask of the single bypassed channel, if any
  assign bypMask = state_q.bypassEn ? (4'h1 << state_q.bypassIdx) : 4'h0; // RULE_03

  // Present vote count and interrupt events from its transitions and from changes of the zone enable
  assign voteCount = tfv_pkg::tripCount(state_q.voteIn);
  assign events[tfv_pkg::IRQ_HALF_BIT] = (voteCount == tfv_pkg::VOTE_HALF) && !state_q.halfPrev;
  assign events[tfv_pkg::IRQ_FULL_BIT] = (voteCount >= tfv_pkg::VOTE_FULL_MIN) && !state_q.fullPrev;
  assign events[tfv_pkg::IRQ_ZONE_BIT] = (|state_q.oscEn) != state_q.zonePrev;

  // Reading the status register clears it
  assign irqClr = (busRdStb && busAddr == tfv_pkg::REG_IRQ_STAT) ? 3'h7 : 3'h0;

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    rdMux = 32'h0;
    case (busAddr)
      tfv_pkg::REG_CTRL: begin
        rdMux[tfv_pkg::CTRL_BYP_EN_BIT] = state_q.bypassEn;
        rdMux[tfv_pkg::CTRL_BYP_IDX_LSB +: 2] = state_q.bypassIdx;
      end
      tfv_pkg::REG_STP_RUN: begin
        rdMux[7:0] = state_q.stpRun;
      end
      tfv_pkg::REG_STP_SETDOWN: begin
        rdMux[7:0] = state_q.stpSetdown;
      end
      tfv_pkg::REG_STATE: begin
        rdMux[3:0] = state_q.voteIn;
        rdMux[7:4] = state_q.avgTrip;
        rdMux[11:8] = state_q.oscEn;
        rdMux[15:12] = halfTripInd;
        rdMux[16] = |cellTrip;
        rdMux[17] = state_q.modeRun;
      end
      tfv_pkg::REG_IRQ_STAT: begin
        rdMux[2:0] = state_q.irqStat;
      end
      tfv_pkg::REG_IRQ_MASK: begin
        rdMux[2:0] = state_q.irqMask;
      end
      default: begin
        rdMux = 32'h0;
      end
    endcase
  end

  // Next state: sync stages, trip functions, vote inputs, registers
  always_comb begin
    state_d = state_q;
    // Channel and mode pins pass two flip-flops before any logic; bus pins feed the logic directly
    state_d.chanMeta = chanIn;
    state_d.chan = state_q.chanMeta;
    state_d.modeMeta = modeRunPin;
    state_d.modeRun = state_q.modeMeta;
    for (int k = 0; k < 4; k++) begin
      // Average power trip has no automatic bypass path
      state_d.avgTrip[k] = state_q.chan[k].powerPct >= stpSel; // RULE_07
      // Zone checked every cycle, no latching
      state_d.oscEn[k] = tfv_pkg::zoneOk(state_q.chan[k]); // RULE_06 RULE_11
    end
    // Oscillation vote input merges upscale trip and inoperative flag
    for (int k = 0; k < 4; k++) begin
      oscVote[k] = (state_q.oscEn[k] && state_q.chan[k].oscUpscale) || state_q.chan[k].avgInop; // RULE_09
    end
    // Bypassed channel removed from every voter
    state_d.voteIn = (state_q.avgTrip | oscVote) & ~bypMask; // RULE_10
    state_d.halfPrev = (voteCount == tfv_pkg::VOTE_HALF);
    state_d.fullPrev = (voteCount >= tfv_pkg::VOTE_FULL_MIN);
    state_d.zonePrev = |state_q.oscEn;
    // Set wins over clear-on-read
    state_d.irqStat = (state_q.irqStat & ~irqClr) | events;
    state_d.rdData = busRdStb ? rdMux : 32'h0;
    if (busWrStb) begin
      case (busAddr)
        tfv_pkg::REG_CTRL: begin
          // A single index field means only one channel can ever be bypassed
          state_d.bypassEn = busWrData[tfv_pkg::CTRL_BYP_EN_BIT]; // RULE_03
          state_d.bypassIdx = busWrData[tfv_pkg::CTRL_BYP_IDX_LSB +: 2];
        end
        tfv_pkg::REG_STP_RUN: begin
          state_d.stpRun = busWrData[7:0];
        end
        tfv_pkg::REG_STP_SETDOWN: begin
          state_d.stpSetdown = busWrData[7:0];
        end
        tfv_pkg::REG_IRQ_MASK: begin
          state_d.irqMask = busWrData[2:0];
        end
        default: begin
          state_d.irqMask = state_q.irqMask;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= '0;
      state_q.stpRun <= tfv_pkg::STP_RUN_RST;
      state_q.stpSetdown <= tfv_pkg::STP_SETDOWN_RST;
      state_q.irqMask <= tfv_pkg::IRQ_MASK_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // Four identical voters, none with a bypass input
  for (genvar v = 0; v < 4; v++) begin : gVoter
    tfv_vote_cell #(
      .NUM_OUT(NUM_OUT)
    ) uCell (
      .clk(clk),
      .sys_rst(sys_rst),
      .voteIn(state_q.voteIn),
      .tripOut(cellTrip[v]),
      .halfTrip(cellHalf[v])
    ); // RULE_03
  end

  assign ptsTrip = cellTrip; // RULE_02
  assign halfTripInd = cellHalf;
  assign busRdData = state_q.rdData;
  assign irq = |(state_q.irqStat & state_q.irqMask);

  default clocking cbMain @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_two_full_all: assert property ( // RULE_05
    (voteCount >= 3'h2) |=> ((&ptsTrip) && (halfTripInd == 4'h0)))
    else $error("two votes did not trip every voter output");

  a_one_half_all: assert property ( // RULE_04
    (voteCount == 3'h1) |=> ((ptsTrip == '0) && (halfTripInd == 4'hf)))
    else $error("single vote not shown as half-trip only");

  a_redundant_pair: assert property ( // RULE_02
    (ptsTrip[0] == ptsTrip[1]) && (ptsTrip[2] == ptsTrip[3]) && (ptsTrip[0] == ptsTrip[3]))
    else $error("redundant trip outputs disagree");

  a_bypass_silent: assert property ( // RULE_10
    ($past(state_q.bypassEn) && $past(state_q.bypassEn, 2)) |-> (state_q.voteIn[$past(state_q.bypassIdx)] == 1'b0))
    else $error("bypassed channel reached the vote");

  a_zone_track: assert property ( // RULE_11
    (state_q.oscEn[0] && !tfv_pkg::zoneOk(state_q.chan[0])) |=> !state_q.oscEn[0])
    else $error("oscillation enable held outside the zone");

  a_zone_limits: assert property ( // RULE_06
    $rose(state_q.oscEn[1]) |-> ($past(state_q.chan[1].powerPct) > 8'h1e && $past(state_q.chan[1].flowPct) < 8'h3c))
    else $error("oscillation enabled outside power and flow limits");

  a_avg_always: assert property ( // RULE_07
    (state_q.avgTrip[2] && !(state_q.bypassEn && state_q.bypassIdx == 2'h2)) |=> state_q.voteIn[2])
    else $error("average power trip did not reach the vote");

  a_setdown_sel: assert property ( // RULE_08
    (!state_q.modeRun && state_q.chan[3].powerPct >= state_q.stpSetdown) |=> state_q.avgTrip[3])
    else $error("setdown threshold not applied outside run");

  a_inop_merge: assert property ( // RULE_09
    (state_q.chan[0].avgInop && !(state_q.bypassEn && state_q.bypassIdx == 2'h0)) |=> state_q.voteIn[0])
    else $error("inoperative flag missing from oscillation vote");

  a_irq_clear: assert property (
    (busRdStb && busAddr == tfv_pkg::REG_IRQ_STAT && events == 3'h0) |=> (state_q.irqStat == 3'h0 && !irq))
    else $error("status read did not clear interrupt bits");

endmodule : tfv_voter

/* verification/tfv_pts_model.sv */
// Relay-side model of the two protection trip systems
module tfv_pts_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0][1:0] ptsTrip,
  output logic [2:0] sysAIn,
  output logic [2:0] sysBIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // Voters 0 and 1 feed trip system A, voters 2 and 3 feed B; either relay of a voter opens its input
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sysAIn <= 3'h0;
      sysBIn <= 3'h0;
    end else begin
      sysAIn <= 3'(ptsTrip[0][0] | ptsTrip[0][1]) + 3'(ptsTrip[1][0] | ptsTrip[1][1]);
      sysBIn <= 3'(ptsTrip[2][0] | ptsTrip[2][1]) + 3'(ptsTrip[3][0] | ptsTrip[3][1]);
    end
  end
endmodule : tfv_pts_model

/* verification/testbench.sv */
// Self-checking bench for the two-of-four trip voter
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0] trip;
    logic [3:0] inop;
    logic half;
    logic full;
  } tfv_row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic modeRunPin = 1'b1;
  tfv_pkg::tfv_chan_in_t [3:0] chanIn = '0;
  logic [7:0] busAddr = 8'h00;
  logic [31:0] busWrData = 32'h0;
  logic busWrStb = 1'b0;
  logic busRdStb = 1'b0;
  logic [31:0] busRdData;
  logic [3:0][1:0] ptsTrip;
  logic [3:0] halfTripInd;
  logic irq;
  logic [2:0] sysAIn;
  logic [2:0] sysBIn;
  logic [31:0] rdVal;
  int fails = 0;
  int checkCount = 0;
  tfv_row_t rows [8] = '{'{4'h0, 4'h0, 1'b0, 1'b0}, '{4'h1, 4'h0, 1'b1, 1'b0}, '{4'h0, 4'h2, 1'b1, 1'b0},
    '{4'h3, 4'h0, 1'b0, 1'b1}, '{4'hc, 4'h0, 1'b0, 1'b1}, '{4'h4, 4'h8, 1'b0, 1'b1}, '{4'hf, 4'h0, 1'b0, 1'b1},
    '{4'h0, 4'h1, 1'b1, 1'b0}};

  // Design and relay model
  tfv_voter dut (.clk(clk), .sys_rst(sys_rst), .chanIn(chanIn), .modeRunPin(modeRunPin), .busAddr(busAddr),
    .busWrData(busWrData), .busWrStb(busWrStb), .busRdStb(busRdStb), .busRdData(busRdData),
    .ptsTrip(ptsTrip), .halfTripInd(halfTripInd), .irq(irq));
  tfv_pts_model relayModel (.clk(clk), .sys_rst(sys_rst), .ptsTrip(ptsTrip), .sysAIn(sysAIn), .sysBIn(sysBIn));

  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    busAddr <= a;
    busWrData <= d;
    busWrStb <= 1'b1;
    @(posedge clk);
    busWrStb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    busAddr <= a;
    busRdStb <= 1'b1;
    @(posedge clk);
    busRdStb <= 1'b0;
    #1;
    v = busRdData;
  endtask : rd

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask : rdChk

  // Channels whose bit is set in pw get power hi, the others lo; then let the trip path settle
  task automatic drive(input logic [3:0] pw, input logic [3:0] inop, input logic [3:0] osc,
                       input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] flow);
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      chanIn[i] <= '{osc[i], inop[i], pw[i] ? hi : lo, flow};
    end
    cyc(8);
  endtask : drive

  task automatic expectOut(input logic half, input logic full);
    chk(32'(ptsTrip), full ? 32'hff : 32'h0);
    chk(32'(halfTripInd), half ? 32'hf : 32'h0);
    chk(32'(sysAIn), full ? 32'h2 : 32'h0);
    chk(32'(sysBIn), full ? 32'h2 : 32'h0);
  endtask : expectOut

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    #1;
    expectOut(1'b0, 1'b0);
    @(posedge clk);
    sys_rst <= 1'b0;
    drive(4'h0, 4'h0, 4'h0, 8'h80, 8'h10, 8'h50);
    rdChk(tfv_pkg::REG_CTRL, 32'h0);
    rdChk(tfv_pkg::REG_STP_RUN, {24'h0, tfv_pkg::STP_RUN_RST});
    rdChk(tfv_pkg::REG_STP_SETDOWN, {24'h0, tfv_pkg::STP_SETDOWN_RST});
    rdChk(tfv_pkg::REG_IRQ_MASK, 32'h0);
    rdChk(8'h3c, 32'h0);
    $display("test reset done");
    for (int r = 0; r < 8; r++) begin
      drive(rows[r].trip, rows[r].inop, 4'h0, 8'h80, 8'h10, 8'h50);
      expectOut(rows[r].half, rows[r].full);
    end
    $display("test rows done");
    // Setdown threshold outside run, at its boundary
    wr(tfv_pkg::REG_STP_SETDOWN, 32'h20);
    rdChk(tfv_pkg::REG_STP_SETDOWN, 32'h20);
    @(posedge clk);
    modeRunPin <= 1'b0;
    drive(4'h9, 4'h0, 4'h0, 8'h20, 8'h1f, 8'h50);
    expectOut(1'b0, 1'b1);
    @(posedge clk);
    modeRunPin <= 1'b1;
    cyc(8);
    expectOut(1'b0, 1'b0);
    $display("test setdown done");
    // Oscillation zone edges and leaving the zone
    drive(4'h0, 4'h0, 4'h3, 8'h80, 8'h1f, 8'h3b);
    expectOut(1'b0, 1'b1);
    drive(4'h0, 4'h0, 4'h3, 8'h80, 8'h1e, 8'h3b);
    expectOut(1'b0, 1'b0);
    drive(4'h0, 4'h0, 4'h3, 8'h80, 8'h1f, 8'h3c);
    expectOut(1'b0, 1'b0);
    drive(4'h0, 4'h0, 4'h1, 8'h80, 8'h1f, 8'h3b);
    expectOut(1'b1, 1'b0);
    $display("test zone done");
    // Bypass of channel 1, then of channel 3
    wr(tfv_pkg::REG_CTRL, 32'h3);
    drive(4'h3, 4'h0, 4'h0, 8'h80, 8'h10, 8'h50);
    expectOut(1'b1, 1'b0);
    drive(4'h1, 4'h2, 4'h0, 8'h80, 8'h10, 8'h50);
    expectOut(1'b1, 1'b0);
    drive(4'h7, 4'h0, 4'h0, 8'h80, 8'h10, 8'h50);
    expectOut(1'b0, 1'b1);
    wr(tfv_pkg::REG_CTRL, 32'h7);
    drive(4'h3, 4'h0, 4'h0, 8'h80, 8'h10, 8'h50);
    expectOut(1'b0, 1'b1);
    rdChk(tfv_pkg::REG_STATE, 32'h00030033);
    $display("test bypass done");
    // Interrupt raised while masked, then unmasked and cleared
    wr(tfv_pkg::REG_CTRL, 32'h0);
    drive(4'h0, 4'h0, 4'h0, 8'h80, 8'h10, 8'h50);
    rd(tfv_pkg::REG_IRQ_STAT, rdVal);
    drive(4'h1, 4'h0, 4'h0, 8'h80, 8'h10, 8'h50);
    chk({31'h0, irq}, 32'h0);
    wr(tfv_pkg::REG_IRQ_MASK, 32'h7);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    rdChk(tfv_pkg::REG_IRQ_STAT, 32'h1);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    drive(4'h3, 4'h0, 4'h0, 8'h80, 8'h10, 8'h50);
    rdChk(tfv_pkg::REG_IRQ_STAT, 32'h2);
    $display("test interrupt done");
    // Reset in mid-run while tripped, then recovery from the still-tripping inputs
    @(posedge clk);
    sys_rst <= 1'b1;
    cyc(2);
    expectOut(1'b0, 1'b0);
    chk({31'h0, irq}, 32'h0);
    @(posedge clk);
    sys_rst <= 1'b0;
    cyc(8);
    expectOut(1'b0, 1'b1);
    rdChk(tfv_pkg::REG_IRQ_MASK, 32'h0);
    $display("test mid reset done");
    conclude();
  end
endmodule : testbench
